// file: pkg/wwg_defs.svh
/*
 Offsets, field positions, reset values and timing counts of the windowed watchdog guard.
 Assumes AHB-Lite byte addressing with one 32-bit word per register.
*/
`ifndef WWG_DEFS_SVH
`define WWG_DEFS_SVH

// Register indices; byte address is four times the index
`define WWG_IDX_CTRL 10'h00c
`define WWG_IDX_TEST_A 10'h00d
`define WWG_IDX_TEST_B 10'h00e
`define WWG_IDX_KEY 10'h00f
`define WWG_IDX_CLK_PICK 10'h010
`define WWG_IDX_STATUS 10'h011

// Control register fields
`define WWG_BIT_WINDOW 7
`define WWG_BIT_STOP_DBG 6
`define WWG_BIT_WMASK 5
`define WWG_RATE_OFF 3'h0

// Service keys
`define WWG_KEY_FIRST 8'h55
`define WWG_KEY_SECOND 8'haa

// Period exponents for rate codes 7 down to 1
`define WWG_EXP_SLOW {5'd24, 5'd23, 5'd22, 5'd20, 5'd18, 5'd16, 5'd14}
`define WWG_EXP_FAST {5'd17, 5'd16, 5'd15, 5'd13, 5'd11, 5'd9, 5'd7}
`define WWG_EXP_LONGEST 5'd24
`define WWG_EXP_FLOOR 5'd2

// Reset value and counter width
`define WWG_TEST_RESET 8'h00
`define WWG_CNT_W 25

`endif

// file: pkg/wwg_pkg.sv
/*
 Types of the windowed watchdog guard.
 Assumes wwg_defs.svh is on the include path.
*/
package wwg_pkg;
	`include "wwg_defs.svh"

	// Captured AHB-Lite address phase
	typedef struct packed {
		logic valid;
		logic write;
		logic [9:0] idx;
	} wwg_addr_phase_t;

	// Software-visible control state
	typedef struct packed {
		logic window_watch_mode;
		logic stop_in_debug;
		logic [2:0] timeout_rate_select;
	} wwg_ctrl_t;

	// Counting-clock selection
	typedef struct packed {
		logic watch_clk_pick_hi;
		logic watch_clk_pick_lo;
	} wwg_clk_pick_t;
endpackage

// file: src/wwg_top.sv
/*
 Windowed watchdog guard: control, service key, test registers and the timeout counter,
 behind an AHB-Lite slave. Assumes counting clocks arrive as one-cycle tick strobes
 synchronous to clk, and that the system reset generator acts on wd_reset_pulse.
*/
`include "wwg_defs.svh"

module wwg_top #(
	parameter int unsigned EXP_TRIM = 0 // Shortens every period by this many powers of two, but never below four counts
) (
	input wire logic clk, // System clock, 125 MHz
	input wire logic nrst, // Asynchronous reset, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size, word only
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic hreadyout, // Slave ready, never stalls
	output logic hresp, // Always OKAY
	output logic [31:0] hrdata, // Read data, registered
	input wire logic special_mode, // Device runs in special mode
	input wire logic background_debug, // Background debug active
	input wire logic stop_mode, // Full or pseudo stop
	input wire logic osc_locked_status, // Oscillator lock status
	input wire logic internal_rc_tick, // Internal RC clock strobe
	input wire logic crystal_tick, // Crystal clock strobe
	input wire logic autonomous_tick, // Autonomous clock strobe
	input wire logic flash_load, // Pulse: load control from flash
	input wire logic [2:0] flash_rate, // Rate value from flash
	input wire logic flash_window, // Window value from flash
	output logic periodic_tick_halt, // Halt request to periodic tick
	output logic wd_reset_pulse // One-cycle system reset request
);
	import wwg_pkg::*;

	wwg_addr_phase_t aph_reg;
	wwg_ctrl_t ctrl_reg;
	wwg_clk_pick_t pick_reg;
	logic once_used_reg;
	logic armed_reg;
	logic half_div_reg;
	logic lock_prev_reg;
	logic [7:0] test_a_reg;
	logic [7:0] test_b_reg;
	logic [`WWG_CNT_W-1:0] cnt_reg;
	logic wr_go;
	logic [7:0] wbyte;
	logic wmask;
	logic enabled;
	logic debug_force;
	logic window_eff;
	logic [4:0] period_exp;
	logic [`WWG_CNT_W-1:0] period_last;
	logic [`WWG_CNT_W-1:0] window_open;
	logic in_window;
	logic src_tick;
	logic halted;
	logic cnt_tick;
	logic expiry;
	logic ctrl_restart;
	logic pick_restart;
	logic key_restart;
	logic key_fault;
	logic restart;
	logic [4:0] exp_raw;

	// Register file needs no wait states, so the slave is always ready
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Address phase capture; only word transfers are expected
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aph_reg <= '0;
		end else if (hready) begin
			aph_reg.valid <= hsel && htrans[1];
			aph_reg.write <= hwrite;
			aph_reg.idx <= haddr[11:2];
		end
	end

	assign wr_go = aph_reg.valid && aph_reg.write;
	assign wbyte = hwdata[7:0];
	assign wmask = wbyte[`WWG_BIT_WMASK];

	// Read data is registered from the address phase; unmapped words read zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hrdata <= '0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[11:2])
				`WWG_IDX_CTRL: hrdata <= {24'h000000, ctrl_reg.window_watch_mode,
					ctrl_reg.stop_in_debug, 3'h0, ctrl_reg.timeout_rate_select};
				`WWG_IDX_TEST_A: hrdata <= {24'h000000, test_a_reg};
				`WWG_IDX_TEST_B: hrdata <= {24'h000000, test_b_reg};
				`WWG_IDX_KEY: hrdata <= 32'h00000000;
				`WWG_IDX_CLK_PICK: hrdata <= {30'h00000000, pick_reg};
				`WWG_IDX_STATUS: hrdata <= {cnt_reg[23:0], 4'h0, in_window, enabled,
					once_used_reg, armed_reg};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	// Control register: mode-dependent write permissions
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= '0;
			once_used_reg <= 1'b0;
		end else if (flash_load) begin
			ctrl_reg.timeout_rate_select <= flash_rate;
			ctrl_reg.window_watch_mode <= flash_window;
		end else if (wr_go && aph_reg.idx == `WWG_IDX_CTRL) begin
			if (special_mode) begin
				ctrl_reg.stop_in_debug <= wbyte[`WWG_BIT_STOP_DBG];
				if (!wmask) begin
					ctrl_reg.window_watch_mode <= wbyte[`WWG_BIT_WINDOW];
					ctrl_reg.timeout_rate_select <= wbyte[2:0];
				end
			end else begin
				if (wbyte[`WWG_BIT_STOP_DBG]) begin
					ctrl_reg.stop_in_debug <= 1'b1;
				end
				// Zero values change nothing but still use the one write
				if (!wmask && !once_used_reg) begin
					once_used_reg <= 1'b1;
					if (wbyte[2:0] != `WWG_RATE_OFF) begin
						ctrl_reg.timeout_rate_select <= wbyte[2:0];
					end
					if (wbyte[`WWG_BIT_WINDOW]) begin
						ctrl_reg.window_watch_mode <= 1'b1;
					end
				end
			end
		end
	end

	// Restart causes from control writes and flash load
	always_comb begin
		ctrl_restart = 1'b0;
		if (flash_load) begin
			ctrl_restart = flash_rate != `WWG_RATE_OFF;
		end else if (wr_go && aph_reg.idx == `WWG_IDX_CTRL) begin
			if (special_mode) begin
				ctrl_restart = 1'b1;
			end else begin
				ctrl_restart = (wbyte[`WWG_BIT_STOP_DBG] && !ctrl_reg.stop_in_debug) ||
					(!wmask && !once_used_reg &&
					(wbyte[2:0] != `WWG_RATE_OFF || wbyte[`WWG_BIT_WINDOW]));
			end
		end
	end

	// Clock pick register and oscillator lock loss
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pick_reg <= '0;
			lock_prev_reg <= 1'b0;
		end else begin
			lock_prev_reg <= osc_locked_status;
			if (wr_go && aph_reg.idx == `WWG_IDX_CLK_PICK) begin
				pick_reg <= wbyte[1:0];
			end
		end
	end

	assign pick_restart = (wr_go && aph_reg.idx == `WWG_IDX_CLK_PICK &&
		wbyte[1:0] != pick_reg) || (lock_prev_reg && !osc_locked_status &&
		!pick_reg.watch_clk_pick_hi && pick_reg.watch_clk_pick_lo);

	// Factory test registers: writes ignored outside special mode
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			test_a_reg <= `WWG_TEST_RESET;
			test_b_reg <= `WWG_TEST_RESET;
		end else if (wr_go && special_mode) begin
			if (aph_reg.idx == `WWG_IDX_TEST_A) begin
				test_a_reg <= wbyte;
			end
			if (aph_reg.idx == `WWG_IDX_TEST_B) begin
				test_b_reg <= wbyte;
			end
		end
	end

	// Period selection
	assign enabled = ctrl_reg.timeout_rate_select != `WWG_RATE_OFF;
	assign debug_force = enabled && background_debug && !ctrl_reg.stop_in_debug &&
		special_mode;
	assign window_eff = ctrl_reg.window_watch_mode && !debug_force;

	always_comb begin
		logic [34:0] slow_tab;
		logic [34:0] fast_tab;
		slow_tab = `WWG_EXP_SLOW;
		fast_tab = `WWG_EXP_FAST;
		exp_raw = `WWG_EXP_LONGEST;
		if (debug_force) begin
			exp_raw = `WWG_EXP_LONGEST;
		end else if (enabled) begin
			if (pick_reg.watch_clk_pick_hi) begin
				exp_raw = fast_tab[5*(ctrl_reg.timeout_rate_select-3'h1) +: 5];
			end else begin
				exp_raw = slow_tab[5*(ctrl_reg.timeout_rate_select-3'h1) +: 5];
			end
		end
		// Trim only shortens simulation; the floor keeps a quarter meaningful
		if (exp_raw >= 5'(EXP_TRIM) + `WWG_EXP_FLOOR) begin
			period_exp = exp_raw - 5'(EXP_TRIM);
		end else begin
			period_exp = `WWG_EXP_FLOOR;
		end
	end

	assign period_last = (`WWG_CNT_W'(1) << period_exp) - `WWG_CNT_W'(1);
	assign window_open = `WWG_CNT_W'(3) << (period_exp - 5'd2);
	assign in_window = cnt_reg >= window_open;

	// Count clock: autonomous strobe halved by a toggle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			half_div_reg <= 1'b0;
		end else if (autonomous_tick) begin
			half_div_reg <= !half_div_reg;
		end
	end

	always_comb begin
		if (pick_reg.watch_clk_pick_hi) begin
			src_tick = autonomous_tick && half_div_reg;
		end else if (pick_reg.watch_clk_pick_lo) begin
			src_tick = crystal_tick;
		end else begin
			src_tick = internal_rc_tick;
		end
	end

	// Stop halts the counter unless the autonomous clock drives it
	assign halted = (ctrl_reg.stop_in_debug && background_debug) ||
		(stop_mode && !pick_reg.watch_clk_pick_hi);
	assign periodic_tick_halt = ctrl_reg.stop_in_debug && background_debug;
	assign cnt_tick = enabled && src_tick && !halted;
	// At or beyond the last count, so a period shortened when debug force ends still expires
	assign expiry = cnt_tick && cnt_reg >= period_last;

	// Service key decoding
	always_comb begin
		key_fault = 1'b0;
		key_restart = 1'b0;
		if (wr_go && aph_reg.idx == `WWG_IDX_KEY && enabled) begin
			if (wbyte != `WWG_KEY_FIRST && wbyte != `WWG_KEY_SECOND) begin
				key_fault = 1'b1;
			end else if (window_eff && !in_window) begin
				key_fault = 1'b1;
			end else if (wbyte == `WWG_KEY_SECOND && armed_reg) begin
				key_restart = 1'b1;
			end
		end
	end

	// First key arms; repeats keep it armed; a restart disarms
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			armed_reg <= 1'b0;
		end else if (restart || wd_reset_pulse) begin
			armed_reg <= 1'b0;
		end else if (wr_go && aph_reg.idx == `WWG_IDX_KEY && enabled && !key_fault &&
			wbyte == `WWG_KEY_FIRST) begin
			armed_reg <= 1'b1;
		end
	end

	assign restart = ctrl_restart || pick_restart || key_restart;

	// Timeout counter
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
		end else if (restart || wd_reset_pulse || expiry || !enabled) begin
			cnt_reg <= '0;
		end else if (cnt_tick) begin
			cnt_reg <= cnt_reg + `WWG_CNT_W'(1);
		end
	end

	// Reset request is a single registered pulse
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wd_reset_pulse <= 1'b0;
		end else begin
			wd_reset_pulse <= !wd_reset_pulse && (expiry || key_fault);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_stop_sticky: assert property (
		(ctrl_reg.stop_in_debug && !special_mode) |=> ctrl_reg.stop_in_debug)
		else $error("debug-stop cleared in normal mode");

	chk_once_lock: assert property (
		(once_used_reg && !special_mode && !flash_load) |=>
		$stable(ctrl_reg.timeout_rate_select) && $stable(ctrl_reg.window_watch_mode))
		else $error("rate or window changed after the single write");

	chk_key_reads_zero: assert property (
		(hready && hsel && htrans[1] && !hwrite && haddr[11:2] == `WWG_IDX_KEY) |=>
		hrdata == 32'h00000000)
		else $error("service key read nonzero");

	chk_bad_key: assert property (
		(wr_go && aph_reg.idx == `WWG_IDX_KEY && enabled && !wd_reset_pulse &&
		wbyte != `WWG_KEY_FIRST && wbyte != `WWG_KEY_SECOND) |=> wd_reset_pulse)
		else $error("wrong key did not reset");

	chk_early_key: assert property (
		(wr_go && aph_reg.idx == `WWG_IDX_KEY && enabled && window_eff &&
		cnt_reg < window_open && !wd_reset_pulse) ##1 1'b1 |-> wd_reset_pulse)
		else $error("service before the window did not reset");

	chk_pulse_single: assert property (
		wd_reset_pulse |=> !wd_reset_pulse && cnt_reg == '0 && !armed_reg)
		else $error("reset request longer than one cycle");

	chk_debug_halt: assert property (
		(ctrl_reg.stop_in_debug && background_debug && !restart && !wd_reset_pulse &&
		enabled) |=> $stable(cnt_reg))
		else $error("counter moved while halted in debug");

	chk_expiry_reset: assert property (
		(expiry && !wd_reset_pulse) |=> wd_reset_pulse ##1 !wd_reset_pulse)
		else $error("expiry did not give one reset pulse");

	chk_idle_when_off: assert property (
		(!enabled && !wd_reset_pulse) |=> !wd_reset_pulse)
		else $error("reset while the watchdog is disabled");

	chk_pair_restart: assert property (
		(key_restart && !expiry && !wd_reset_pulse) |=> cnt_reg == '0 && !armed_reg)
		else $error("key pair did not restart the period");

	chk_pick_restart: assert property (
		(wr_go && aph_reg.idx == `WWG_IDX_CLK_PICK && wbyte[1:0] != pick_reg) |=>
		cnt_reg == '0)
		else $error("clock pick change did not restart");

	chk_lock_loss: assert property (
		($fell(osc_locked_status) && !pick_reg.watch_clk_pick_hi &&
		pick_reg.watch_clk_pick_lo) |=> cnt_reg == '0)
		else $error("lock loss did not restart");

	chk_flash_start: assert property (
		(flash_load && flash_rate != `WWG_RATE_OFF) |=> cnt_reg == '0 && enabled)
		else $error("flash rate did not start a period");

	chk_special_restart: assert property (
		(wr_go && aph_reg.idx == `WWG_IDX_CTRL && special_mode && !flash_load) |=>
		cnt_reg == '0)
		else $error("special-mode control write did not restart");

	chk_test_guard: assert property (
		(wr_go && !special_mode) |=> $stable(test_a_reg) && $stable(test_b_reg))
		else $error("test register written in normal mode");

	// Stop freezes the count on the slow clocks but not on the autonomous one
	chk_stop_halt: assert property (
		(stop_mode && !pick_reg.watch_clk_pick_hi && enabled && !restart &&
		!wd_reset_pulse) |=> $stable(cnt_reg))
		else $error("counter moved in stop on slow clock");

	chk_stop_keeps: assert property (
		(stop_mode && pick_reg.watch_clk_pick_hi && enabled && src_tick &&
		!periodic_tick_halt && !restart && !expiry && !wd_reset_pulse) |=> cnt_reg != '0)
		else $error("counter halted in stop on autonomous clock");
endmodule

// file: verif/wwg_top_tb.sv
/*
 Self-checking bench for the windowed watchdog guard, driving its AHB-Lite slave.
 Assumes wwg_pkg and the design top are compiled first; periods are trimmed for speed.
*/
module wwg_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import wwg_pkg::*;
	localparam int unsigned TRIM = 10;
	// Rate 1 period in clocks; count strobes come every other clock
	localparam int PER = 2 * (1 << (14 - TRIM));
	logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, hready, hresp;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2, flash_rate = 0;
	logic special_mode = 0, background_debug = 0, stop_mode = 0, osc_locked_status = 1;
	logic tick = 0, flash_load = 0, flash_window = 0, periodic_tick_halt, wd_reset_pulse;
	int fails = 0, cmp_count = 0, pulses = 0, n, p0;

	wwg_top #(.EXP_TRIM(TRIM)) dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .special_mode(special_mode),
		.background_debug(background_debug), .stop_mode(stop_mode),
		.osc_locked_status(osc_locked_status), .internal_rc_tick(tick), .crystal_tick(tick),
		.autonomous_tick(tick), .flash_load(flash_load), .flash_rate(flash_rate),
		.flash_window(flash_window), .periodic_tick_halt(periodic_tick_halt),
		.wd_reset_pulse(wd_reset_pulse));

	initial begin
		forever #4 clk = ~clk;
	end

	// One strobe every other clock feeds every counting source
	always @(posedge clk) begin
		tick <= ~tick;
		if (wd_reset_pulse === 1'b1) begin
			pulses <= pulses + 1;
		end
	end

	task automatic check(string name, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Single word transfer; read data taken at the data-phase edge
	task automatic ahb(logic wr, logic [31:0] a, logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task automatic rd_chk(string name, logic [31:0] a, logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		check(name, exp, q);
	endtask

	task automatic rst_dut(logic spec);
		@(posedge clk);
		nrst <= 1'b0;
		special_mode <= spec;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
	endtask

	// Bounded wait; n is the clocks spent before the pulse was seen
	task automatic wait_pulse(int lim);
		n = 0;
		while (wd_reset_pulse !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic t_regs();
		rst_dut(1'b0);
		rd_chk("ctrl reset", 32'h30, 32'h0);
		rd_chk("key read", 32'h3c, 32'h0);
		rd_chk("unmapped", 32'h100, 32'h0);
		rd_chk("status reset", 32'h44, 32'h0);
		check("hresp okay", 0, hresp);
		ahb(1'b1, 32'h34, 32'h5a);
		rd_chk("test_a normal", 32'h34, 32'h0);
		rst_dut(1'b1);
		ahb(1'b1, 32'h34, 32'h5a);
		rd_chk("test_a special", 32'h34, 32'h5a);
		rd_chk("test_b reset", 32'h38, 32'h0);
		$display("test regs done");
	endtask

	task automatic t_normal();
		rst_dut(1'b0);
		ahb(1'b1, 32'h30, 32'h21);
		rd_chk("masked write", 32'h30, 32'h0);
		ahb(1'b1, 32'h30, 32'h00);
		ahb(1'b1, 32'h30, 32'h01);
		rd_chk("write once", 32'h30, 32'h0);
		p0 = pulses;
		ahb(1'b1, 32'h3c, 32'h12);
		repeat (PER) @(posedge clk);
		check("disabled key", p0, pulses);
		ahb(1'b1, 32'h30, 32'h60);
		ahb(1'b1, 32'h30, 32'h20);
		rd_chk("stop bit sticky", 32'h30, 32'h40);
		background_debug <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		check("tick halt", 1, periodic_tick_halt);
		background_debug <= 1'b0;
		@(posedge clk);
		check("tick run", 0, periodic_tick_halt);
		$display("test normal done");
	endtask

	task automatic t_special();
		rst_dut(1'b1);
		ahb(1'b1, 32'h30, 32'h40);
		ahb(1'b1, 32'h30, 32'h20);
		rd_chk("stop clear special", 32'h30, 32'h0);
		ahb(1'b1, 32'h30, 32'h81);
		ahb(1'b1, 32'h30, 32'h01);
		rd_chk("rewrite special", 32'h30, 32'h01);
		background_debug <= 1'b1;
		p0 = pulses;
		repeat (2 * PER) @(posedge clk);
		check("debug longest", p0, pulses);
		ahb(1'b1, 32'h30, 32'h41);
		p0 = pulses;
		repeat (2 * PER) @(posedge clk);
		check("debug halt", p0, pulses);
		check("tick halt special", 1, periodic_tick_halt);
		background_debug <= 1'b0;
		ahb(1'b1, 32'h30, 32'h01);
		repeat (PER / 2) @(posedge clk);
		ahb(1'b1, 32'h30, 32'h01);
		wait_pulse(3 * PER);
		check("special restart", 1, n >= PER - 4 && n <= PER + 4);
		$display("test special done");
	endtask

	task automatic t_expire();
		rst_dut(1'b0);
		ahb(1'b1, 32'h30, 32'h01);
		wait_pulse(3 * PER);
		check("expiry time", 1, n >= PER - 4 && n <= PER + 4);
		@(posedge clk);
		check("pulse width", 0, wd_reset_pulse);
		rst_dut(1'b0);
		flash_rate <= 3'h1;
		flash_load <= 1'b1;
		@(posedge clk);
		flash_load <= 1'b0;
		wait_pulse(3 * PER);
		check("flash start", 1, n >= PER - 4 && n <= PER + 4);
		rst_dut(1'b0);
		ahb(1'b1, 32'h30, 32'h01);
		repeat (PER / 2) @(posedge clk);
		ahb(1'b1, 32'h40, 32'h01);
		wait_pulse(3 * PER);
		check("pick restart", 1, n >= PER - 4 && n <= PER + 4);
		repeat (PER / 2) @(posedge clk);
		osc_locked_status <= 1'b0;
		wait_pulse(3 * PER);
		check("lock loss", 1, n >= PER - 4 && n <= PER + 4);
		osc_locked_status <= 1'b1;
		rd_chk("pick readback", 32'h40, 32'h1);
		stop_mode <= 1'b1;
		ahb(1'b1, 32'h40, 32'h2);
		wait_pulse(3 * PER);
		check("stop fast", 1, n >= PER / 2 - 4 && n <= PER / 2 + 4);
		ahb(1'b1, 32'h40, 32'h0);
		p0 = pulses;
		repeat (2 * PER) @(posedge clk);
		check("stop halt", p0, pulses);
		stop_mode <= 1'b0;
		$display("test expire done");
	endtask

	task automatic t_service();
		rst_dut(1'b0);
		ahb(1'b1, 32'h30, 32'h01);
		p0 = pulses;
		repeat (8) begin
			repeat (PER / 4) @(posedge clk);
			ahb(1'b1, 32'h3c, 32'h55);
			ahb(1'b1, 32'h3c, 32'h55);
			rd_chk("key between", 32'h3c, 32'h0);
			ahb(1'b1, 32'h3c, 32'haa);
		end
		check("serviced", p0, pulses);
		ahb(1'b1, 32'h3c, 32'h12);
		wait_pulse(4);
		check("bad key", 1, n < 4);
		$display("test service done");
	endtask

	task automatic t_window();
		rst_dut(1'b0);
		ahb(1'b1, 32'h30, 32'h82);
		p0 = pulses;
		repeat (4 * PER * 25 / 32) @(posedge clk);
		ahb(1'b1, 32'h3c, 32'h55);
		ahb(1'b1, 32'h3c, 32'h55);
		ahb(1'b1, 32'h3c, 32'haa);
		check("late service", p0, pulses);
		ahb(1'b1, 32'h3c, 32'h55);
		wait_pulse(4);
		check("early key", 1, n < 4);
		$display("test window done");
	endtask

	task automatic summarize();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Hang guard, well beyond the fewer than a thousand clocks the tests need
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		summarize();
	end

	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_normal();
		t_special();
		t_expire();
		t_service();
		t_window();
		summarize();
	end
endmodule
